// ==== src/buck_fault_sequencer.sv ====
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// R1: any flagged fault tri-states the pwm output
// R2: external temp trip flags fault at once, releases below threshold minus hysteresis
// R3: die overtemperature flags fault at once, releases below lower point
// R4: overvoltage flags fault and latches off until enable or supply cycles
// R5: undervoltage lockout flags fault and tri-states pwm, releases automatically
// R6: current limit never flags fault; repeated trips cause hiccup wait and restart
// R7: hiccup count adds two per overcurrent cycle, subtracts one otherwise
// R8: pre-bias above nominal at start flags fault and latches off
// R9: after enable, pwm waits the initialisation delay before soft-start
// R10: enable low stops the controller and pwm
// R11: power-good released a fixed delay after feedback becomes good
// R12: soft-start length picked from sixteen settings, open selects 2048 us
// R13: soft-stop ramp lasts as long as the soft-start setting
// R14: outside-audio mode forces low side on after long gap between pulses
// R15: pwm 0 means low side, 1 high side, off means both off
// R16: external low on the fault line is a system fault, pwm tri-stated
module buck_fault_sequencer #(
  parameter int p_tick_cycles = buck_pkg::TICK_CYCLES,
  parameter int p_hiccup_us = buck_pkg::HICCUP_US
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // comparators and enable
  input wire logic i_enable,
  input wire logic i_ext_temp_sense_in,
  input wire logic i_ext_temp_release,
  input wire logic i_die_overtemp_detect,
  input wire logic i_die_cool,
  input wire logic i_overvoltage_sense_in,
  input wire logic i_uvlo,
  input wire logic i_prebias_above,
  input wire logic i_feedback_sense,
  // loop side
  input wire logic i_pwm_request,
  input wire logic i_sw_cycle,
  input wire logic i_overcurrent,
  // fault line, open drain
  input wire logic i_fault_line_n,
  output logic o_fault_line_n_out,
  output logic o_fault_line_n_oe,
  // power stage
  output logic o_pwm_drive_out,
  output logic o_pwm_drive_oe,
  output logic o_low_side_force_out,
  // power good, open drain
  output logic o_supply_ok_out,
  output logic o_supply_ok_oe
);
  regs_if rif ();

  buck_pkg::seq_state_t state_ff, nxt_state;
  logic [15:0] div_ff, nxt_div;
  logic tick;
  logic [buck_pkg::TIME_W-1:0] timer_ff, nxt_timer;
  logic ext_temp_ff, nxt_ext_temp;
  logic die_ff, nxt_die;
  logic ovp_ff, nxt_ovp;
  logic prebias_ff, nxt_prebias;
  logic uvlo_ff;
  logic sysfault_ff, nxt_sysfault;
  logic fault_oe_ff, nxt_fault_oe;
  logic fault_oe_d_ff;
  logic pwm_oe_ff, nxt_pwm_oe;
  logic pwm_out_ff, nxt_pwm_out;
  logic [buck_pkg::TIME_W-1:0] pg_cnt_ff, nxt_pg_cnt;
  logic pg_ok_ff, nxt_pg_ok;
  logic [buck_pkg::TIME_W-1:0] oa_cnt_ff, nxt_oa_cnt;
  logic ls_ff, nxt_ls;
  logic latched, live_fault, switching, hiccup_trip;
  logic [buck_pkg::TIME_W-1:0] ss_len;

  function automatic logic reached(input logic [buck_pkg::TIME_W-1:0] t, input int lim);
    return t >= buck_pkg::TIME_W'(lim);
  endfunction

  ahb_regs u_regs (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .rif(rif.bus)
  );

  // counter cleared whenever the stage is not switching
  hiccup_counter u_hiccup (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cycle(i_sw_cycle),
    .i_overcurrent(i_overcurrent), .i_clear(!switching), .o_trip(hiccup_trip)
  );

  // microsecond tick divider
  always_comb begin
    tick = (div_ff == 16'(p_tick_cycles - 1));
    nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
  end

  assign ss_len = buck_pkg::ss_us(rif.ss_sel); // R12 R13

  // fault flags; a new trip beats its own release in the same cycle
  always_comb begin
    nxt_ext_temp = i_ext_temp_sense_in || (ext_temp_ff && !i_ext_temp_release); // R2
    nxt_die = i_die_overtemp_detect || (die_ff && !i_die_cool); // R3
    nxt_ovp = i_overvoltage_sense_in || (ovp_ff && i_enable); // R4
    nxt_prebias = (i_prebias_above && state_ff == buck_pkg::ST_INIT) ||
                  (prebias_ff && i_enable); // R8
    // own drive may still sit on the wire for a cycle after release
    nxt_sysfault = !i_fault_line_n && !fault_oe_ff && !fault_oe_d_ff; // R16
    nxt_fault_oe = nxt_ext_temp || nxt_die || nxt_ovp || nxt_prebias || i_uvlo; // R2 R5
  end

  assign latched = ovp_ff || prebias_ff;
  assign live_fault = fault_oe_ff || sysfault_ff;

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    unique case (state_ff)
      buck_pkg::ST_OFF: begin
        nxt_timer = '0;
        if (i_enable && !latched) begin
          nxt_state = buck_pkg::ST_INIT;
        end
      end
      buck_pkg::ST_INIT: begin
        if (!i_enable) begin
          nxt_state = buck_pkg::ST_OFF; // R10
        end else if (latched) begin
          nxt_state = buck_pkg::ST_LATCHED;
        end else if (live_fault) begin
          nxt_timer = '0;
        end else if (tick && reached(timer_ff, buck_pkg::INIT_US)) begin
          nxt_state = buck_pkg::ST_SOFTSTART; // R9
          nxt_timer = '0;
        end else if (tick) begin
          nxt_timer = timer_ff + buck_pkg::TIME_W'(1);
        end
      end
      buck_pkg::ST_SOFTSTART, buck_pkg::ST_RUN: begin
        if (!i_enable) begin
          nxt_state = rif.soft_stop_en ? buck_pkg::ST_SOFTSTOP : buck_pkg::ST_OFF; // R10 R13
          nxt_timer = '0;
        end else if (latched) begin
          nxt_state = buck_pkg::ST_LATCHED; // R4 R8
        end else if (live_fault) begin
          nxt_state = buck_pkg::ST_INIT;
          nxt_timer = '0;
        end else if (hiccup_trip) begin
          nxt_state = buck_pkg::ST_HICCUP; // R6
          nxt_timer = '0;
        end else if (state_ff == buck_pkg::ST_SOFTSTART && tick) begin
          nxt_timer = timer_ff + buck_pkg::TIME_W'(1);
          if (reached(timer_ff, int'(ss_len))) begin
            nxt_state = buck_pkg::ST_RUN; // R12
          end
        end
      end
      buck_pkg::ST_SOFTSTOP: begin
        if (latched || live_fault) begin
          nxt_state = buck_pkg::ST_OFF;
        end else if (tick && reached(timer_ff, int'(ss_len))) begin
          nxt_state = buck_pkg::ST_OFF; // R13
        end else if (tick) begin
          nxt_timer = timer_ff + buck_pkg::TIME_W'(1);
        end
      end
      buck_pkg::ST_HICCUP: begin
        if (!i_enable) begin
          nxt_state = buck_pkg::ST_OFF;
        end else if (latched) begin
          nxt_state = buck_pkg::ST_LATCHED;
        end else if (tick && reached(timer_ff, p_hiccup_us)) begin
          nxt_state = buck_pkg::ST_SOFTSTART; // R6
          nxt_timer = '0;
        end else if (tick) begin
          nxt_timer = timer_ff + buck_pkg::TIME_W'(1);
        end
      end
      buck_pkg::ST_LATCHED: begin
        if (!i_enable) begin
          nxt_state = buck_pkg::ST_OFF; // R4 R8
        end
      end
      default: begin
        nxt_state = buck_pkg::ST_OFF;
      end
    endcase
  end

  // pwm drives only while ramping or running and nothing is flagged
  always_comb begin
    switching = (state_ff == buck_pkg::ST_SOFTSTART) || (state_ff == buck_pkg::ST_RUN);
    nxt_pwm_oe = (nxt_state == buck_pkg::ST_SOFTSTART || nxt_state == buck_pkg::ST_RUN ||
                  nxt_state == buck_pkg::ST_SOFTSTOP) && !nxt_fault_oe &&
                 !nxt_sysfault; // R1 R5 R16
    nxt_pwm_out = nxt_pwm_oe && i_pwm_request; // R15
  end

  // power good after a fixed delay of good feedback while running
  always_comb begin
    nxt_pg_cnt = pg_cnt_ff;
    nxt_pg_ok = pg_ok_ff;
    if (state_ff != buck_pkg::ST_RUN || !i_feedback_sense) begin
      nxt_pg_cnt = '0;
      nxt_pg_ok = 1'b0;
    end else if (tick && !pg_ok_ff) begin
      nxt_pg_cnt = pg_cnt_ff + buck_pkg::TIME_W'(1);
      nxt_pg_ok = reached(pg_cnt_ff, buck_pkg::PG_DELAY_US); // R11
    end
  end

  // outside audio: gap since last high-side pulse, saturating
  always_comb begin
    nxt_oa_cnt = oa_cnt_ff;
    if (nxt_pwm_out || !switching) begin
      nxt_oa_cnt = '0;
    end else if (tick && !reached(oa_cnt_ff, buck_pkg::OA_TIMEOUT_US + 2)) begin
      nxt_oa_cnt = oa_cnt_ff + buck_pkg::TIME_W'(1);
    end
    nxt_ls = rif.oa_en && switching && !nxt_pwm_out &&
             (oa_cnt_ff > buck_pkg::TIME_W'(buck_pkg::OA_TIMEOUT_US)); // R14
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_ff <= buck_pkg::ST_OFF;
      div_ff <= 16'h0000;
      timer_ff <= '0;
      ext_temp_ff <= 1'b0;
      die_ff <= 1'b0;
      ovp_ff <= 1'b0;
      prebias_ff <= 1'b0;
      uvlo_ff <= 1'b0;
      sysfault_ff <= 1'b0;
      fault_oe_ff <= 1'b0;
      fault_oe_d_ff <= 1'b0;
      pwm_oe_ff <= 1'b0;
      pwm_out_ff <= 1'b0;
      pg_cnt_ff <= '0;
      pg_ok_ff <= 1'b0;
      oa_cnt_ff <= '0;
      ls_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      timer_ff <= nxt_timer;
      ext_temp_ff <= nxt_ext_temp;
      die_ff <= nxt_die;
      ovp_ff <= nxt_ovp;
      prebias_ff <= nxt_prebias;
      uvlo_ff <= i_uvlo;
      sysfault_ff <= nxt_sysfault;
      fault_oe_ff <= nxt_fault_oe;
      fault_oe_d_ff <= fault_oe_ff;
      pwm_oe_ff <= nxt_pwm_oe;
      pwm_out_ff <= nxt_pwm_out;
      pg_cnt_ff <= nxt_pg_cnt;
      pg_ok_ff <= nxt_pg_ok;
      oa_cnt_ff <= nxt_oa_cnt;
      ls_ff <= nxt_ls;
    end
  end

  // outputs; power good pulls low until released
  assign o_fault_line_n_out = 1'b0;
  assign o_fault_line_n_oe = fault_oe_ff;
  assign o_pwm_drive_out = pwm_out_ff;
  assign o_pwm_drive_oe = pwm_oe_ff;
  assign o_low_side_force_out = ls_ff;
  assign o_supply_ok_out = 1'b0;
  assign o_supply_ok_oe = !pg_ok_ff; // R11

  always_comb begin
    rif.status = 32'h00000000;
    rif.status[buck_pkg::STAT_STATE_LSB +: 3] = state_ff;
    rif.status[buck_pkg::STAT_EXT_TEMP_BIT] = ext_temp_ff;
    rif.status[buck_pkg::STAT_DIE_BIT] = die_ff;
    rif.status[buck_pkg::STAT_OVP_BIT] = ovp_ff;
    rif.status[buck_pkg::STAT_UVLO_BIT] = uvlo_ff;
    rif.status[buck_pkg::STAT_PREBIAS_BIT] = prebias_ff;
    rif.status[buck_pkg::STAT_SYSFAULT_BIT] = sysfault_ff;
    rif.status[buck_pkg::STAT_PGOOD_BIT] = pg_ok_ff;
    rif.status[buck_pkg::STAT_LSFORCE_BIT] = ls_ff;
  end

  // assertion helper: cycles spent in start-up delay
  logic [31:0] init_len_ff;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || state_ff != buck_pkg::ST_INIT) begin
      init_len_ff <= 32'h00000000;
    end else begin
      init_len_ff <= init_len_ff + 32'h00000001;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence init_to_ramp;
    (state_ff == buck_pkg::ST_INIT) ##1 (state_ff == buck_pkg::ST_SOFTSTART);
  endsequence

  sequence stop_no_ramp;
    $fell(i_enable) && !rif.soft_stop_en && switching;
  endsequence

  fault_tristate_a: assert property ((ext_temp_ff || die_ff || ovp_ff || prebias_ff)
    |-> !o_pwm_drive_oe) else $error("pwm driven while fault flagged"); // R1
  temp_trip_a: assert property (i_ext_temp_sense_in |=> ext_temp_ff && o_fault_line_n_oe)
    else $error("temp trip not flagged"); // R2
  die_hold_a: assert property (die_ff && !i_die_cool |=> die_ff)
    else $error("die fault released early"); // R3
  ovp_latch_a: assert property (ovp_ff && i_enable |=> ovp_ff && !o_pwm_drive_oe)
    else $error("overvoltage latch lost"); // R4
  uvlo_flag_a: assert property (i_uvlo |=> o_fault_line_n_oe && !o_pwm_drive_oe)
    else $error("uvlo not flagged"); // R5
  oc_no_fault_a: assert property (o_fault_line_n_oe |->
    (ext_temp_ff || die_ff || ovp_ff || prebias_ff || uvlo_ff))
    else $error("fault line without flagged cause"); // R6
  init_delay_a: assert property (init_to_ramp |->
    $past(init_len_ff) >= 32'(buck_pkg::INIT_US * p_tick_cycles))
    else $error("soft-start before init delay"); // R9
  enable_off_a: assert property (stop_no_ramp |=> !o_pwm_drive_oe[*2])
    else $error("pwm kept after enable low"); // R10
  pg_cause_a: assert property (!o_supply_ok_oe |-> $past(state_ff) == buck_pkg::ST_RUN)
    else $error("power good outside run"); // R11
  oa_force_a: assert property (o_low_side_force_out |-> $past(rif.oa_en) && !o_pwm_drive_out)
    else $error("low side forced outside audio mode"); // R14
  sys_fault_a: assert property (sysfault_ff |-> !o_pwm_drive_oe)
    else $error("pwm driven during system fault"); // R16
endmodule

// ==== src/buck_pkg.sv ====
package buck_pkg;
  // clock and time base
  localparam int CLOCK_NS = 20;
  localparam int US_NS = 1000;
  localparam int TICK_CYCLES = (US_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int TIME_W = 16;
  // delays in microseconds
  localparam int INIT_US = 250;
  localparam int PG_DELAY_US = 200;
  localparam int HICCUP_US = 8000;
  localparam int OA_TIMEOUT_US = 32;
  // hiccup counter
  localparam int HICCUP_LIMIT = 16;
  localparam int HICCUP_UP = 2;
  localparam int HICCUP_DOWN = 1;
  localparam int HICCUP_W = 5;
  // register map, byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam int CTRL_SS_LSB = 0;
  localparam int CTRL_SOFTSTOP_BIT = 4;
  localparam int CTRL_OA_BIT = 5;
  localparam logic [3:0] SS_SEL_OPEN = 4'hF;
  localparam logic [31:0] CTRL_RESET = 32'h0000000F;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_EXT_TEMP_BIT = 4;
  localparam int STAT_DIE_BIT = 5;
  localparam int STAT_OVP_BIT = 6;
  localparam int STAT_UVLO_BIT = 7;
  localparam int STAT_PREBIAS_BIT = 8;
  localparam int STAT_SYSFAULT_BIT = 9;
  localparam int STAT_PGOOD_BIT = 10;
  localparam int STAT_LSFORCE_BIT = 11;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF, ST_INIT, ST_SOFTSTART, ST_RUN, ST_SOFTSTOP, ST_HICCUP, ST_LATCHED
  } seq_state_t;

  // soft-start length in microseconds; code F is the open input
  function automatic logic [TIME_W-1:0] ss_us(input logic [3:0] sel);
    logic [TIME_W-1:0] t;
    t = 16'h0800;
    unique case (sel)
      4'h0: t = 16'h0040;
      4'h1: t = 16'h0080;
      4'h2: t = 16'h0100;
      4'h3: t = 16'h0200;
      4'h4: t = 16'h0300;
      4'h5: t = 16'h0400;
      4'h6: t = 16'h0600;
      4'h7: t = 16'h0800;
      4'h8: t = 16'h0C00;
      4'h9: t = 16'h1000;
      4'hA: t = 16'h1800;
      4'hB: t = 16'h2000;
      4'hC: t = 16'h4000;
      4'hD: t = 16'h6000;
      4'hE: t = 16'h8000;
      4'hF: t = 16'h0800;
    endcase
    return t;
  endfunction
endpackage

// ==== src/regs_if.sv ====
`timescale 1ns/1ps
interface regs_if;
  logic [3:0] ss_sel;
  logic soft_stop_en;
  logic oa_en;
  logic [31:0] status;
  modport bus (output ss_sel, output soft_stop_en, output oa_en, input status);
  modport core (input ss_sel, input soft_stop_en, input oa_en, output status);
endinterface

// ==== src/hiccup_counter.sv ====
`timescale 1ns/1ps
module hiccup_counter (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // per switching cycle
  input wire logic i_cycle,
  input wire logic i_overcurrent,
  input wire logic i_clear,
  // trip level
  output logic o_trip
);
  logic [buck_pkg::HICCUP_W-1:0] count_ff;
  logic [buck_pkg::HICCUP_W-1:0] nxt_count;

  // up by two on overcurrent, down by one otherwise, never below zero
  always_comb begin
    nxt_count = count_ff;
    if (i_clear) begin
      nxt_count = '0;
    end else if (i_cycle && i_overcurrent) begin
      if (count_ff >= buck_pkg::HICCUP_W'(buck_pkg::HICCUP_LIMIT - buck_pkg::HICCUP_UP)) begin
        nxt_count = buck_pkg::HICCUP_W'(buck_pkg::HICCUP_LIMIT); // R7
      end else begin
        nxt_count = count_ff + buck_pkg::HICCUP_W'(buck_pkg::HICCUP_UP); // R7
      end
    end else if (i_cycle && count_ff != '0) begin
      nxt_count = count_ff - buck_pkg::HICCUP_W'(buck_pkg::HICCUP_DOWN); // R7
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign o_trip = (count_ff >= buck_pkg::HICCUP_W'(buck_pkg::HICCUP_LIMIT)); // R7
endmodule

// ==== src/ahb_regs.sv ====
`timescale 1ns/1ps
module ahb_regs (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // toward the core
  regs_if.bus rif
);
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [7:0] addr_ff;
  logic [7:0] nxt_addr;
  logic addr_phase;

  // only whole-word single transfers are expected; hsize is not checked
  assign addr_phase = i_hsel && i_hready && (i_htrans == buck_pkg::HTRANS_NONSEQ);

  // zero wait: read data latched at address phase, writes land in data phase
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rdata = 32'h00000000;
    nxt_wr_pend = addr_phase && i_hwrite;
    nxt_addr = addr_ff;
    if (wr_pend_ff && addr_ff == buck_pkg::CTRL_ADDR) begin
      nxt_ctrl = {26'h0, i_hwdata[5:0]};
    end
    if (addr_phase) begin
      nxt_addr = i_haddr;
      if (!i_hwrite && i_haddr == buck_pkg::CTRL_ADDR) begin
        nxt_rdata = ctrl_ff;
      end else if (!i_hwrite && i_haddr == buck_pkg::STATUS_ADDR) begin
        nxt_rdata = rif.status;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_ff <= buck_pkg::CTRL_RESET;
      rdata_ff <= 32'h00000000;
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      wr_pend_ff <= nxt_wr_pend;
      addr_ff <= nxt_addr;
    end
  end

  assign o_hrdata = rdata_ff;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign rif.ss_sel = ctrl_ff[buck_pkg::CTRL_SS_LSB +: 4];
  assign rif.soft_stop_en = ctrl_ff[buck_pkg::CTRL_SOFTSTOP_BIT];
  assign rif.oa_en = ctrl_ff[buck_pkg::CTRL_OA_BIT];
endmodule

// ==== verif/power_stage_model.sv ====
`timescale 1ns/1ps
// behavioural power stage on the far side of the pwm pin
module power_stage_model (
  // from the controller
  input wire logic i_pwm,
  input wire logic i_pwm_oe,
  // bench request to pull the shared fault wire low
  input wire logic i_pull_fault,
  // transistor states and fault wire drive
  output logic o_hs_on,
  output logic o_ls_on,
  output logic o_fault_pull
);
  // a floating pwm pin turns both transistors off, so no shoot-through
  always_comb begin
    o_hs_on = i_pwm_oe & i_pwm;
    o_ls_on = i_pwm_oe & !i_pwm;
    o_fault_pull = i_pull_fault;
  end
endmodule

// ==== verif/tb_buck_fault_sequencer.sv ====
`timescale 1ns/1ps
module tb_buck_fault_sequencer;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h00000000, hrdata, rd;
  logic hready, hresp;
  logic en = 1'b0, overvoltage_sense_in = 1'b0, prebias = 1'b0, fb = 1'b0, req = 1'b0;
  logic swc = 1'b0, oc = 1'b0, pull = 1'b0;
  logic [2:0] trip = 3'h0;
  logic [1:0] clr = 2'h3;
  logic fault_out, fault_oe, pwm, pwm_oe, ls_force, pg_out, pg_oe;
  logic hs_on, ls_on, stage_pull;
  wire fault_n = !(fault_oe | stage_pull);
  int failures = 0;
  int checks = 0;
  int n;

  // time scaled down: 2 cycles per microsecond, short hiccup wait
  buck_fault_sequencer #(.p_tick_cycles(2), .p_hiccup_us(10)) DUT (
    .i_clock(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_enable(en), .i_ext_temp_sense_in(trip[0]), .i_ext_temp_release(clr[0]),
    .i_die_overtemp_detect(trip[1]), .i_die_cool(clr[1]),
    .i_overvoltage_sense_in(overvoltage_sense_in), .i_uvlo(trip[2]), .i_prebias_above(prebias),
    .i_feedback_sense(fb), .i_pwm_request(req), .i_sw_cycle(swc),
    .i_overcurrent(oc), .i_fault_line_n(fault_n), .o_fault_line_n_out(fault_out),
    .o_fault_line_n_oe(fault_oe), .o_pwm_drive_out(pwm), .o_pwm_drive_oe(pwm_oe),
    .o_low_side_force_out(ls_force), .o_supply_ok_out(pg_out),
    .o_supply_ok_oe(pg_oe));

  power_stage_model stage (.i_pwm(pwm), .i_pwm_oe(pwm_oe), .i_pull_fault(pull),
    .o_hs_on(hs_on), .o_ls_on(ls_on), .o_fault_pull(stage_pull));

  always #10 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one single-word transfer; waits on hready in both phases
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= buck_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 400; i++) begin
      xfer(buck_pkg::STATUS_ADDR, 1'b0, 32'h00000000);
      if (rd[2:0] === s) break;
    end
    chk(rd[2:0], s);
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic oc_pulse(input logic v);
    @(posedge clk);
    swc <= 1'b1;
    oc <= v;
    @(posedge clk);
    swc <= 1'b0;
    oc <= 1'b0;
  endtask

  // watchdog sized well above the longest expected run
  initial begin
    #(60000 * 20);
    failures++;
    report_and_stop();
  end

  initial begin
    cycles(20);
    rst <= 1'b0;
    chk({pg_oe, pwm_oe, fault_oe}, 3'h4);
    chk({hresp, fault_out, pg_out}, 3'h0);
    xfer(buck_pkg::CTRL_ADDR, 1'b0, 32'h00000000);
    chk(rd, buck_pkg::CTRL_RESET);
    xfer(8'h40, 1'b0, 32'h00000000);
    chk(rd, 32'h00000000);
    // every soft-start code is accepted and read back
    for (int c = 0; c < 16; c++) begin
      xfer(buck_pkg::CTRL_ADDR, 1'b1, 32'hFFFFFFE0 | c);
      xfer(buck_pkg::CTRL_ADDR, 1'b0, 32'h00000000);
      chk(rd, 32'h00000020 | c);
    end
    xfer(buck_pkg::CTRL_ADDR, 1'b1, 32'h00000020);
    // pre-bias at start latches off until enable cycles
    prebias <= 1'b1;
    en <= 1'b1;
    cycles(10);
    chk(fault_oe, 1'b1);
    wait_state(3'h6);
    prebias <= 1'b0;
    cycles(20);
    chk(fault_oe, 1'b1);
    en <= 1'b0;
    cycles(4);
    chk(fault_oe, 1'b0);
    // start-up: no pwm before the 250 us delay
    en <= 1'b1;
    for (n = 0; n < 2000 && pwm_oe !== 1'b1; n++) @(posedge clk);
    chk(n >= 502, 1'b1);
    chk(pwm_oe, 1'b1);
    wait_state(3'h3);
    req <= 1'b1;
    cycles(4);
    chk({pwm, hs_on, ls_on}, 3'h6);
    req <= 1'b0;
    cycles(4);
    chk({pwm, hs_on, ls_on}, 3'h1);
    cycles(36);
    chk(ls_force, 1'b0);
    cycles(60);
    chk(ls_force, 1'b1);
    fb <= 1'b1;
    cycles(380);
    chk(pg_oe, 1'b1);
    cycles(50);
    chk(pg_oe, 1'b0);
    // hiccup count: 7 up, 2 down, 1 up stays below 16, one more trips
    for (int i = 0; i < 7; i++) oc_pulse(1'b1);
    oc_pulse(1'b0);
    oc_pulse(1'b0);
    oc_pulse(1'b1);
    cycles(3);
    xfer(buck_pkg::STATUS_ADDR, 1'b0, 32'h00000000);
    chk(rd[2:0], 3'h3);
    oc_pulse(1'b1);
    cycles(2);
    xfer(buck_pkg::STATUS_ADDR, 1'b0, 32'h00000000);
    chk(rd[2:0], 3'h5);
    chk({fault_oe, pwm_oe}, 2'h0);
    wait_state(3'h2);
    // self-clearing faults: ext temp and die hold until release, uvlo at once
    for (int k = 0; k < 3; k++) begin
      trip[k] <= 1'b1;
      if (k < 2) clr[k] <= 1'b0;
      cycles(4);
      chk({fault_oe, pwm_oe, hs_on, ls_on}, 4'h8);
      trip[k] <= 1'b0;
      cycles(5);
      chk(fault_oe, k < 2);
      if (k < 2) clr[k] <= 1'b1;
      cycles(5);
      chk(fault_oe, 1'b0);
    end
    // overvoltage latches until enable falls
    wait_state(3'h3);
    overvoltage_sense_in <= 1'b1;
    cycles(3);
    chk({fault_oe, pwm_oe}, 2'h2);
    overvoltage_sense_in <= 1'b0;
    wait_state(3'h6);
    cycles(20);
    chk(fault_oe, 1'b1);
    en <= 1'b0;
    cycles(4);
    chk({fault_oe, pwm_oe}, 2'h0);
    wait_state(3'h0);
    // a low forced on the fault wire from outside
    en <= 1'b1;
    wait_state(3'h3);
    pull <= 1'b1;
    cycles(3);
    chk(pwm_oe, 1'b0);
    xfer(buck_pkg::STATUS_ADDR, 1'b0, 32'h00000000);
    chk(rd[buck_pkg::STAT_SYSFAULT_BIT], 1'b1);
    pull <= 1'b0;
    // soft-stop lasts the 64 us soft-start setting
    xfer(buck_pkg::CTRL_ADDR, 1'b1, 32'h00000030);
    wait_state(3'h3);
    en <= 1'b0;
    cycles(100);
    chk(pwm_oe, 1'b1);
    cycles(100);
    chk(pwm_oe, 1'b0);
    // open soft-start setting lasts 2048 us, then enable drops with no soft-stop
    xfer(buck_pkg::CTRL_ADDR, 1'b1, buck_pkg::CTRL_RESET);
    en <= 1'b1;
    wait_state(3'h2);
    cycles(3800);
    xfer(buck_pkg::STATUS_ADDR, 1'b0, 32'h00000000);
    chk(rd[2:0], 3'h2);
    wait_state(3'h3);
    en <= 1'b0;
    cycles(3);
    chk(pwm_oe, 1'b0);
    report_and_stop();
  end
endmodule
